// file: shared/can_obj_consts.svh
// Register offsets, field positions and reset values of the object status and wake-up block.
`ifndef CAN_OBJ_CONSTS_SVH
`define CAN_OBJ_CONSTS_SVH
`define OBJ_COUNT 32
`define OBJ_HALF 16
`define OFF_PEND_HI 12'h144
`define OFF_VALID_LO 12'h160
`define OFF_VALID_HI 12'h164
`define OFF_WU_CTRL 12'h168
`define OFF_WU_STAT 12'h16c
`define OFF_IRQ_STAT 12'h170
`define OFF_IRQ_EN 12'h174
`define OFF_IRQ_CLR 12'h178
`define WU_EN_BIT 0
`define WU_STS_BIT 0
`define IRQ_WAKE_BIT 0
`define IRQ_PEND_BIT 1
`define IRQ_BITS 2
`define RESET_WORD 32'h0000_0000
`define RESET_HALF 16'h0000
`endif

// file: shared/can_obj_pkg.sv
// Types shared by the object status and wake-up block.
package can_obj_pkg;
  typedef logic [11:0] reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef logic [4:0] obj_num_t;
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PEND_HI,
    SEL_VALID_LO,
    SEL_VALID_HI,
    SEL_WU_CTRL,
    SEL_WU_STAT,
    SEL_IRQ_STAT,
    SEL_IRQ_EN
  } reg_sel_e;
endpackage

// file: shared/obj_vec_if.sv
// Carrier between the register front end and the message object flag store.
`timescale 1ns/1ns
`default_nettype none
interface obj_vec_if;
  logic [4:0] sw_obj_num;
  logic sw_valid_we;
  logic sw_valid_val;
  logic sw_pend_we;
  logic sw_pend_val;
  logic [31:0] handler_pend_set;
  logic [31:0] valid_vec;
  logic [31:0] pend_vec;
  modport store (
    input sw_obj_num,
    input sw_valid_we,
    input sw_valid_val,
    input sw_pend_we,
    input sw_pend_val,
    input handler_pend_set,
    output valid_vec,
    output pend_vec
  );
  modport ctrl (
    output sw_obj_num,
    output sw_valid_we,
    output sw_valid_val,
    output sw_pend_we,
    output sw_pend_val,
    output handler_pend_set,
    input valid_vec,
    input pend_vec
  );
endinterface
`default_nettype wire

// file: src/object_state.sv
// Valid and interrupt pending flags of all message objects.
`timescale 1ns/1ns
`default_nettype none
`include "can_obj_consts.svh"
module object_state
  import can_obj_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  obj_vec_if.store ov
);
  logic [31:0] valid_reg;
  logic [31:0] pend_reg;
  logic [31:0] pend_next;
  logic [31:0] sel_mask;
  logic [31:0] set_mask;
  logic [31:0] clr_mask;

  always_comb
  begin
    sel_mask = 32'h0000_0001 << ov.sw_obj_num;
    // The handler only acts on configured objects.
    set_mask = ov.handler_pend_set & valid_reg;
    clr_mask = 32'h0000_0000;
    if (ov.sw_pend_we)
    begin
      if (ov.sw_pend_val)
        set_mask = set_mask | sel_mask;
      else
        clr_mask = sel_mask;
    end
    // A handler event in the same cycle as a software clear keeps the flag set.
    pend_next = (pend_reg & ~clr_mask) | set_mask;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      valid_reg <= `RESET_WORD;
    else if (ov.sw_valid_we)
      valid_reg[ov.sw_obj_num] <= ov.sw_valid_val;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_reg <= `RESET_WORD;
    else
      pend_reg <= pend_next;
  end

  assign ov.valid_vec = valid_reg;
  assign ov.pend_vec = pend_reg;

  a_valid_hold: assert property (@(posedge clk) disable iff (rst)
    !ov.sw_valid_we |=> $stable(valid_reg))
    else $error("Valid flags changed without a software write.");
endmodule
`default_nettype wire

// file: src/can_object_status_and_wakeup.sv
// Register front end for message object status vectors and bus wake-up.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "can_obj_consts.svh"
// Overview of operation
// - Pending flags of objects 17 to 32 read in bits 15 to 0 of a read-only register, 1 meaning interrupt source.
// - Valid flags change only through the interface register set writes, never by bus writes.
// - The handler ignores objects whose valid flag is 0 and processes those whose flag is 1.
// - The low valid vector reports objects 1 to 16 in bits 15 to 0, upper bits reserved.
// - The high valid vector reports objects 17 to 32 in bits 15 to 0, upper bits reserved.
// - Bit n of the low valid vector maps to object n plus one, bit n of the high vector to object n plus 17, so bit 15 to object 32.
// - Bit 0 of the wake-up control register enables wake-up when 1 and disables it when 0.
// - While enabled, a falling edge on the receive pin wakes the system.
// - A wake-up event sets the wake-up status flag, which software clears by writing 0.
// - Pending flags are set or cleared by software and set by the handler after a transfer.
module can_object_status_and_wakeup
  import can_obj_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire reg_addr_t addr,
  input wire reg_data_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output reg_data_t rdata,
  input wire obj_num_t sw_obj_num,
  input wire logic sw_valid_we,
  input wire logic sw_valid_val,
  input wire logic sw_pend_we,
  input wire logic sw_pend_val,
  input wire logic [31:0] handler_pend_set,
  input wire logic bus_receive_pin,
  output logic [31:0] valid_flags,
  output logic wakeup_req,
  output logic irq
);
  obj_vec_if ov ();

  reg_sel_e sel;
  reg_data_t rdata_reg;
  reg_data_t rdata_next;
  logic wu_en_reg;
  logic wu_sts_reg;
  logic rx_prev_reg;
  logic rx_fall;
  logic wu_clear;
  logic [15:0] pend_hi_prev_reg;
  logic pend_rise;
  logic [`IRQ_BITS-1:0] irq_stat_reg;
  logic [`IRQ_BITS-1:0] irq_en_reg;
  logic [`IRQ_BITS-1:0] irq_event;
  logic [`IRQ_BITS-1:0] irq_clr;
  logic [31:0] stray_set;

  assign ov.sw_obj_num = sw_obj_num;
  assign ov.sw_valid_we = sw_valid_we;
  assign ov.sw_valid_val = sw_valid_val;
  assign ov.sw_pend_we = sw_pend_we;
  assign ov.sw_pend_val = sw_pend_val;
  assign ov.handler_pend_set = handler_pend_set;

  object_state u_state (
    .clk(clk),
    .rst(rst),
    .ov(ov.store)
  );

  always_comb
  begin
    unique case (addr)
      `OFF_PEND_HI: sel = SEL_PEND_HI;
      `OFF_VALID_LO: sel = SEL_VALID_LO;
      `OFF_VALID_HI: sel = SEL_VALID_HI;
      `OFF_WU_CTRL: sel = SEL_WU_CTRL;
      `OFF_WU_STAT: sel = SEL_WU_STAT;
      `OFF_IRQ_STAT: sel = SEL_IRQ_STAT;
      `OFF_IRQ_EN: sel = SEL_IRQ_EN;
      default: sel = SEL_NONE;
    endcase
  end

  // Read mux. Unmapped and write-only addresses, and all reserved bits, read as zero.
  always_comb
  begin
    rdata_next = `RESET_WORD;
    unique case (sel)
      SEL_PEND_HI: rdata_next[15:0] = ov.pend_vec[31:16];
      SEL_VALID_LO: rdata_next[15:0] = ov.valid_vec[15:0];
      SEL_VALID_HI: rdata_next[15:0] = ov.valid_vec[31:16];
      SEL_WU_CTRL: rdata_next[`WU_EN_BIT] = wu_en_reg;
      SEL_WU_STAT: rdata_next[`WU_STS_BIT] = wu_sts_reg;
      SEL_IRQ_STAT: rdata_next[`IRQ_BITS-1:0] = irq_stat_reg;
      SEL_IRQ_EN: rdata_next[`IRQ_BITS-1:0] = irq_en_reg;
      SEL_NONE: rdata_next = `RESET_WORD;
    endcase
  end

  // Read data stand only in the cycle after the strobe so stale values never linger.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= `RESET_WORD;
    else if (rd_en)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= `RESET_WORD;
  end

  assign rdata = rdata_reg;

  // Only bit 0 is stored; the reserved bits of the write are dropped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wu_en_reg <= 1'b0;
    else if (wr_en && sel == SEL_WU_CTRL)
      wu_en_reg <= wdata[`WU_EN_BIT];
  end

  // The receive line idles recessive high, so the previous sample resets to 1.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_prev_reg <= 1'b1;
    else
      rx_prev_reg <= bus_receive_pin;
  end

  assign rx_fall = wu_en_reg && rx_prev_reg && !bus_receive_pin;
  assign wu_clear = wr_en && sel == SEL_WU_STAT && !wdata[`WU_STS_BIT];

  // An edge seen in the cycle of a software clear keeps the flag set.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wu_sts_reg <= 1'b0;
    else
      wu_sts_reg <= rx_fall | (wu_sts_reg & !wu_clear);
  end

  assign wakeup_req = wu_sts_reg;
  assign valid_flags = ov.valid_vec;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_hi_prev_reg <= `RESET_HALF;
    else
      pend_hi_prev_reg <= ov.pend_vec[31:16];
  end

  assign pend_rise = |(ov.pend_vec[31:16] & ~pend_hi_prev_reg);

  always_comb
  begin
    irq_event = '0;
    irq_event[`IRQ_WAKE_BIT] = rx_fall;
    irq_event[`IRQ_PEND_BIT] = pend_rise;
    irq_clr = '0;
    if (wr_en && sel == SEL_NONE && addr == `OFF_IRQ_CLR)
      irq_clr = wdata[`IRQ_BITS-1:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_en_reg <= '0;
    else if (wr_en && sel == SEL_IRQ_EN)
      irq_en_reg <= wdata[`IRQ_BITS-1:0];
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // Handler requests aimed at unconfigured objects that are not yet pending.
  assign stray_set = handler_pend_set & ~ov.valid_vec & ~ov.pend_vec;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_read(logic [11:0] a);
    rd_en && addr == a;
  endsequence

  sequence s_rx_fall;
    wu_en_reg && rx_prev_reg && !bus_receive_pin;
  endsequence

  sequence s_write(logic [11:0] a);
    wr_en && addr == a;
  endsequence

  sequence s_wu_clear_write;
    wr_en && addr == `OFF_WU_STAT && !wdata[`WU_STS_BIT];
  endsequence

  sequence s_pend_hi_rise;
    |(ov.pend_vec[31:16] & ~pend_hi_prev_reg);
  endsequence

  a_read_pend_hi: assert property (s_read(`OFF_PEND_HI) |=> rdata == {16'h0000, $past(ov.pend_vec[31:16])})
    else $error("High pending vector read back wrong.");

  a_valid_bus_ro: assert property (
    wr_en && (sel == SEL_VALID_LO || sel == SEL_VALID_HI) && !sw_valid_we |=> $stable(ov.valid_vec))
    else $error("Bus write altered a valid vector.");

  a_invalid_ignored: assert property (!sw_pend_we |=> (ov.pend_vec & $past(stray_set)) == 32'h0000_0000)
    else $error("Handler set a pending flag of an invalid object.");

  a_read_valid_lo: assert property (s_read(`OFF_VALID_LO) |=> rdata == {16'h0000, $past(ov.valid_vec[15:0])})
    else $error("Low valid vector read back wrong.");

  a_read_valid_hi: assert property (s_read(`OFF_VALID_HI) |=> rdata == {16'h0000, $past(ov.valid_vec[31:16])})
    else $error("High valid vector read back wrong.");

  a_valid_obj_map: assert property (
    sw_valid_we && sw_obj_num == 5'h1f && sw_valid_val ##1 !sw_valid_we
    ##1 s_read(`OFF_VALID_HI) |=> rdata[15])
    else $error("Object 32 not shown at bit 15 of the high vector.");

  a_wakeup_enable: assert property (s_write(`OFF_WU_CTRL)
    |=> wu_en_reg == $past(wdata[`WU_EN_BIT]))
    else $error("Wake-up enable write did not land.");

  a_wake_on_edge: assert property (s_rx_fall |=> wu_sts_reg && wakeup_req && irq_stat_reg[`IRQ_WAKE_BIT])
    else $error("Falling edge did not wake the system.");

  a_wake_disabled: assert property (!wu_en_reg && !wu_sts_reg |=> !wu_sts_reg)
    else $error("Wake-up flag set while disabled.");

  a_wu_clear: assert property (wr_en && addr == `OFF_WU_STAT && !wdata[0] && !rx_fall |=> !wu_sts_reg)
    else $error("Writing 0 did not clear the wake-up flag.");

  a_pend_sw_set: assert property (sw_pend_we && sw_pend_val |=> ov.pend_vec[$past(sw_obj_num)])
    else $error("Software pending set did not take.");

  a_pend_handler: assert property (handler_pend_set[20] && ov.valid_vec[20] |=> ov.pend_vec[20])
    else $error("Handler event on a valid object lost.");

  a_rdata_idle: assert property (!rd_en |=> rdata == 32'h0000_0000)
    else $error("Read data present without a read strobe.");

  a_reserved_zero: assert property (s_read(`OFF_WU_STAT) |=> rdata[31:1] == 31'h0)
    else $error("Reserved bits of wake-up status not zero.");

  // Read-back of the wake-up and interrupt registers, with all reserved bits held at zero.
  a_read_wu_ctrl: assert property (s_read(`OFF_WU_CTRL)
    |=> rdata == {31'h0, $past(wu_en_reg)})
    else $error("Wake-up enable read back wrong.");

  a_read_wu_stat: assert property (s_read(`OFF_WU_STAT)
    |=> rdata == {31'h0, $past(wu_sts_reg)})
    else $error("Wake-up status read back wrong.");

  a_read_irq_stat: assert property (s_read(`OFF_IRQ_STAT)
    |=> rdata == {30'h0, $past(irq_stat_reg)})
    else $error("Interrupt status read back wrong.");

  a_read_irq_en: assert property (s_read(`OFF_IRQ_EN)
    |=> rdata == {30'h0, $past(irq_en_reg)})
    else $error("Interrupt enable read back wrong.");

  a_read_clr_zero: assert property (s_read(`OFF_IRQ_CLR)
    |=> rdata == 32'h0000_0000)
    else $error("Write-only clear register did not read zero.");

  a_read_unmapped: assert property (rd_en && sel == SEL_NONE
    |=> rdata == 32'h0000_0000)
    else $error("Unmapped address did not read zero.");

  // Wake-up enable and status move only on their own register writes or on a seen edge.
  a_wu_en_hold: assert property (!(wr_en && addr == `OFF_WU_CTRL)
    |=> $stable(wu_en_reg))
    else $error("Wake-up enable changed without a write.");

  a_wu_write_one: assert property (s_write(`OFF_WU_STAT) ##0 wdata[`WU_STS_BIT] && wu_sts_reg
    |=> wu_sts_reg)
    else $error("Writing 1 cleared the wake-up status.");

  a_wu_sts_hold: assert property (wu_sts_reg && !(wr_en && addr == `OFF_WU_STAT)
    |=> wu_sts_reg)
    else $error("Wake-up status dropped without a clear.");

  a_wake_req_drop: assert property (s_wu_clear_write ##0 !rx_fall
    |=> !wakeup_req)
    else $error("Wake request stayed high after a clear.");

  a_edge_single: assert property (s_rx_fall
    |=> !rx_fall)
    else $error("One falling edge was seen twice.");

  a_rx_prev_track: assert property (1'b1
    |=> rx_prev_reg == $past(bus_receive_pin))
    else $error("Receive line history lost a sample.");

  // Flag store: each write touches only its own object, and handler sets survive a software clear.
  a_valid_sw_write: assert property (sw_valid_we
    |=> ov.valid_vec[$past(sw_obj_num)] == $past(sw_valid_val))
    else $error("Valid flag write did not land.");

  a_valid_one_obj: assert property (sw_valid_we
    |=> ((ov.valid_vec ^ $past(ov.valid_vec)) & ~(32'h0000_0001 << $past(sw_obj_num))) == 32'h0000_0000)
    else $error("Valid write changed another object.");

  a_pend_sw_clear: assert property (sw_pend_we && !sw_pend_val
    && !(handler_pend_set[sw_obj_num] && ov.valid_vec[sw_obj_num]) |=> !ov.pend_vec[$past(sw_obj_num)])
    else $error("Software pending clear did not take.");

  a_pend_one_obj: assert property (sw_pend_we && handler_pend_set == 32'h0000_0000
    |=> ((ov.pend_vec ^ $past(ov.pend_vec)) & ~(32'h0000_0001 << $past(sw_obj_num))) == 32'h0000_0000)
    else $error("Pending write changed another object.");

  a_pend_hold: assert property (!sw_pend_we && handler_pend_set == 32'h0000_0000
    |=> $stable(ov.pend_vec))
    else $error("Pending flags changed with no request.");

  // Interrupt status bits are sticky until their clear bit is written.
  a_pend_irq_event: assert property (s_pend_hi_rise
    |=> irq_stat_reg[`IRQ_PEND_BIT])
    else $error("New pending flag raised no interrupt event.");

  a_irq_pend_hold: assert property (irq_stat_reg[`IRQ_PEND_BIT] && !(wr_en && addr == `OFF_IRQ_CLR)
    |=> irq_stat_reg[`IRQ_PEND_BIT])
    else $error("Pending event bit dropped without a clear.");

  a_irq_wake_hold: assert property (irq_stat_reg[`IRQ_WAKE_BIT] && !(wr_en && addr == `OFF_IRQ_CLR)
    |=> irq_stat_reg[`IRQ_WAKE_BIT])
    else $error("Wake event bit dropped without a clear.");

  a_irq_clear: assert property (s_write(`OFF_IRQ_CLR) ##0 wdata[`IRQ_WAKE_BIT] && !rx_fall
    |=> !irq_stat_reg[`IRQ_WAKE_BIT])
    else $error("Wake event bit survived its clear.");

  a_irq_en_write: assert property (s_write(`OFF_IRQ_EN)
    |=> irq_en_reg == $past(wdata[`IRQ_BITS-1:0]))
    else $error("Interrupt enable write did not land.");
endmodule
`default_nettype wire

// file: test/can_rx_model.sv
// Behavioural model of the transceiver that drives the bus receive line.
`timescale 1ns/1ns
`default_nettype none
module can_rx_model
(
  input wire logic clk,
  input wire logic dominant_req,
  output logic bus_receive_pin
);
  logic [2:0] low_cnt = 3'h0;
  // The line rests recessive (high). A request pulls it dominant for a few bit times.
  always @(posedge clk)
  begin
    if (dominant_req)
    begin
      low_cnt <= 3'h4;
    end
    else if (low_cnt != 3'h0)
    begin
      low_cnt <= low_cnt - 3'h1;
    end
  end
  assign bus_receive_pin = (low_cnt == 3'h0);
endmodule
`default_nettype wire

// file: test/can_object_status_and_wakeup_bench.sv
// Self-checking testbench of the object status and wake-up block.
`timescale 1ns/1ns
`default_nettype none
`include "can_obj_consts.svh"
module can_object_status_and_wakeup_bench;
  import can_obj_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_addr_t addr = 12'h000;
  reg_data_t wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  reg_data_t rdata;
  obj_num_t sw_obj_num = 5'h00;
  logic sw_valid_we = 1'b0;
  logic sw_valid_val = 1'b0;
  logic sw_pend_we = 1'b0;
  logic sw_pend_val = 1'b0;
  logic [31:0] handler_pend_set = 32'h0;
  logic bus_receive_pin;
  logic dominant_req = 1'b0;
  logic [31:0] valid_flags;
  logic wakeup_req;
  logic irq;
  int fail_count = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  can_object_status_and_wakeup i_can_object_status_and_wakeup (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sw_obj_num(sw_obj_num),
    .sw_valid_we(sw_valid_we), .sw_valid_val(sw_valid_val), .sw_pend_we(sw_pend_we),
    .sw_pend_val(sw_pend_val), .handler_pend_set(handler_pend_set), .bus_receive_pin(bus_receive_pin),
    .valid_flags(valid_flags), .wakeup_req(wakeup_req), .irq(irq));
  can_rx_model i_can_rx_model (.clk(clk), .dominant_req(dominant_req), .bus_receive_pin(bus_receive_pin));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input reg_addr_t a, input reg_data_t exp, input string what);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata, exp, what);
  endtask
  task automatic obj_write(input obj_num_t n, input logic vwe, input logic pwe, input logic val);
    @(posedge clk);
    sw_obj_num <= n;
    sw_valid_we <= vwe;
    sw_pend_we <= pwe;
    sw_valid_val <= val;
    sw_pend_val <= val;
    @(posedge clk);
    sw_valid_we <= 1'b0;
    sw_pend_we <= 1'b0;
  endtask
  task automatic handler_hit(input logic [31:0] bits);
    @(posedge clk);
    handler_pend_set <= bits;
    @(posedge clk);
    handler_pend_set <= 32'h0;
  endtask
  // The model needs one edge to pull the line low; the design sees it at once and flags it on the next edge.
  task automatic bus_edge_chk(input logic exp);
    @(posedge clk);
    dominant_req <= 1'b1;
    @(posedge clk);
    dominant_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, wakeup_req}, {31'h0, exp}, "wake request");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic test_reset();
    rd_chk(`OFF_PEND_HI, `RESET_WORD, "pending hi");
    rd_chk(`OFF_VALID_LO, `RESET_WORD, "valid lo");
    rd_chk(`OFF_VALID_HI, `RESET_WORD, "valid hi");
    rd_chk(`OFF_WU_CTRL, `RESET_WORD, "wake ctrl");
    rd_chk(12'h100, 32'h0, "unmapped");
    rd_chk(`OFF_IRQ_CLR, 32'h0, "clear reads zero");
    $display("test reset done");
  endtask
  task automatic test_valid();
    obj_write(5'h00, 1'b1, 1'b0, 1'b1);
    obj_write(5'h1f, 1'b1, 1'b0, 1'b1);
    #1;
    check(valid_flags, 32'h8000_0001, "valid flags");
    rd_chk(`OFF_VALID_LO, 32'h0000_0001, "object 1");
    rd_chk(`OFF_VALID_HI, 32'h0000_8000, "object 32");
    wr(`OFF_VALID_HI, 32'hffff_ffff);
    wr(`OFF_VALID_LO, 32'h0000_0000);
    rd_chk(`OFF_VALID_HI, 32'h0000_8000, "valid hi after write");
    rd_chk(`OFF_VALID_LO, 32'h0000_0001, "valid lo after write");
    $display("test valid done");
  endtask
  task automatic test_pending();
    handler_hit(32'h0010_0000);
    rd_chk(`OFF_PEND_HI, 32'h0, "invalid object ignored");
    obj_write(5'h14, 1'b1, 1'b0, 1'b1);
    handler_hit(32'h0010_0000);
    rd_chk(`OFF_PEND_HI, 32'h0000_0010, "object 21 pending");
    rd_chk(`OFF_IRQ_STAT, 32'h0000_0002, "pending event");
    wr(`OFF_IRQ_EN, 32'h0000_0002);
    #1;
    check({31'h0, irq}, 32'h1, "irq on");
    rd_chk(`OFF_IRQ_EN, 32'h0000_0002, "irq enable");
    obj_write(5'h1f, 1'b0, 1'b1, 1'b1);
    rd_chk(`OFF_PEND_HI, 32'h0000_8010, "object 32 set by software");
    obj_write(5'h1f, 1'b0, 1'b1, 1'b0);
    obj_write(5'h14, 1'b0, 1'b1, 1'b0);
    rd_chk(`OFF_PEND_HI, 32'h0, "pending cleared");
    wr(`OFF_IRQ_CLR, 32'h0000_0002);
    #1;
    check({31'h0, irq}, 32'h0, "irq off");
    $display("test pending done");
  endtask
  task automatic test_wakeup();
    bus_edge_chk(1'b0);
    wr(`OFF_WU_CTRL, 32'hffff_ffff);
    rd_chk(`OFF_WU_CTRL, 32'h0000_0001, "wake enable");
    wr(`OFF_IRQ_EN, 32'h0000_0001);
    bus_edge_chk(1'b1);
    check({31'h0, irq}, 32'h1, "wake irq");
    rd_chk(`OFF_WU_STAT, 32'h0000_0001, "wake status");
    wr(`OFF_WU_STAT, 32'h0000_0001);
    rd_chk(`OFF_WU_STAT, 32'h0000_0001, "status kept");
    wr(`OFF_WU_STAT, 32'h0000_0000);
    rd_chk(`OFF_WU_STAT, 32'h0, "status cleared");
    wr(`OFF_IRQ_CLR, 32'h0000_0001);
    wr(`OFF_WU_CTRL, 32'h0);
    rd_chk(`OFF_WU_CTRL, 32'h0, "wake disabled");
    check({31'h0, irq}, 32'h0, "irq cleared");
    $display("test wakeup done");
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_valid();
    test_pending();
    test_wakeup();
    print_verdict();
  end
endmodule
`default_nettype wire
